//--- rtl/cimf_top.sv
// Trigger qualification and mask filter for two counter inputs, arming on input A triggers only
//
// Functional notes
// - With filter on, first qualified trigger of a cycle starts mask interval.
// - During mask, every further band crossing on filtered input is discarded.
// - Mask length is three quarters of filter-frequency period.
// - After mask ends, next trigger is accepted: one count per cycle.
// - Filter frequency accepted from 1 Hz up to 3 MHz.
// - Filter allowed on one input only and only in some functions.
// - Frequency, period-average, RPM with auto trigger: hysteresis is amplitude/3.
// - Four arming modes: free-run, manual, external, burst.
// - Measuring period opens and closes on qualified trigger events.
// - Trigger registered only after full hysteresis band traverse.
// - Free-run opens new measurement after processing, preparation and trigger.
`timescale 1ns/1ps
`default_nettype none
`include "cimf_defs.svh"
module cimf_top
	import cimf_pkg::*;
(
	input wire logic ref_clk,
	input wire logic arst_n,
	input wire logic [`CIMF_ADDR_W-1:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [31:0] rdata,
	input wire cimf_cmp_t cmp_a,
	input wire cimf_cmp_t cmp_b,
	input wire logic ext_arm,
	input wire logic gate_expired,
	input wire logic result_taken,
	output logic trig_a,
	output logic trig_b,
	output logic meas_open,
	output logic meas_done,
	output logic [15:0] hyst_mv
);
	cimf_ctrl_t ctrl_reg, ctrl_next;
	logic [31:0] freq_reg, freq_next;
	logic [31:0] mcyc_reg, mcyc_next;
	logic [15:0] ampl_reg, ampl_next;
	logic [15:0] hyst_reg, hyst_next;
	logic [31:0] count_reg, count_next;
	logic [31:0] rdata_reg, rdata_next;
	logic restart_reg, restart_next;
	logic ta_reg, tb_reg, open_reg, done_reg;
	logic ta_w, tb_w, mask_a, mask_b, filt_ok, fa, fb, qtrig;
	logic ext_prev_reg, armed_reg, armed_next;
	cimf_state_t st_reg, st_next;

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [31:0] mask_len(input logic [31:0] hz);
		logic [63:0] p;
		p = 64'(`CIMF_CLK_HZ) * 64'(`CIMF_MASK_NUM);
		mask_len = 32'(p / (64'(hz) * 64'(`CIMF_MASK_DEN)));
	endfunction

	function automatic logic func_auto_hyst(input cimf_func_t f);
		func_auto_hyst = (f == CIMF_FN_FREQ) || (f == CIMF_FN_PERAVG) || (f == CIMF_FN_RPM);
	endfunction

	// Time functions excluded from filtering
	assign filt_ok = ctrl_reg.filt_en && func_auto_hyst(ctrl_reg.func);
	assign fa = filt_ok && !ctrl_reg.filt_chan_b;
	assign fb = filt_ok && ctrl_reg.filt_chan_b;

	cimf_mask u_mask_a (
		.ref_clk(ref_clk), .arst_n(arst_n), .cmp(cmp_a),
		.slope_neg(ctrl_reg.slope_neg_a), .filt_en(fa),
		.mask_cycles(mcyc_reg), .trig(ta_w), .masking(mask_a)
	);
	cimf_mask u_mask_b (
		.ref_clk(ref_clk), .arst_n(arst_n), .cmp(cmp_b),
		.slope_neg(ctrl_reg.slope_neg_b), .filt_en(fb),
		.mask_cycles(mcyc_reg), .trig(tb_w), .masking(mask_b)
	);

	// ----------------------------------------
	// Register port
	// ----------------------------------------
	always_comb begin
		ctrl_next = ctrl_reg;
		freq_next = freq_reg;
		mcyc_next = mcyc_reg;
		ampl_next = ampl_reg;
		restart_next = 1'b0;
		rdata_next = 32'h0;
		if (wr) begin
			case (addr)
				`CIMF_REG_CTRL: ctrl_next = cimf_ctrl_t'(wdata[$bits(cimf_ctrl_t)-1:0]);
				`CIMF_REG_FREQ: begin
					// Out-of-range frequency is refused, old value kept
					if (wdata >= `CIMF_FILT_HZ_MIN && wdata <= `CIMF_FILT_HZ_MAX) begin
						freq_next = wdata;
						mcyc_next = mask_len(wdata);
					end
				end
				`CIMF_REG_CMD: restart_next = wdata[0];
				`CIMF_REG_AMPL: ampl_next = wdata[15:0];
				default: ;
			endcase
		end
		if (rd) begin
			case (addr)
				`CIMF_REG_CTRL: rdata_next = 32'(ctrl_reg);
				`CIMF_REG_FREQ: rdata_next = freq_reg;
				`CIMF_REG_STAT: rdata_next = {26'h0, mask_b, mask_a, armed_reg, st_reg, open_reg};
				`CIMF_REG_AMPL: rdata_next = {16'h0, ampl_reg};
				`CIMF_REG_HYST: rdata_next = {16'h0, hyst_reg};
				`CIMF_REG_COUNT: rdata_next = count_reg;
				`CIMF_REG_MTIME: rdata_next = mcyc_reg;
				default: rdata_next = 32'h0;
			endcase
		end
		// Variable band only with auto trigger in the averaging functions
		if (ctrl_reg.auto_trig && func_auto_hyst(ctrl_reg.func)) begin
			hyst_next = 16'(ampl_reg / `CIMF_HYST_DIV);
		end else begin
			hyst_next = `CIMF_HYST_FIX_MV;
		end
	end

	// ----------------------------------------
	// Arming and measuring period
	// ----------------------------------------
	assign qtrig = ta_w;
	always_comb begin
		st_next = st_reg;
		armed_next = armed_reg;
		count_next = count_reg;
		case (st_reg)
			CIMF_ST_IDLE: begin
				// Preparation done; free-run rearms itself
				case (ctrl_reg.arm)
					CIMF_ARM_FREE: st_next = CIMF_ST_WAIT;
					CIMF_ARM_MANUAL: if (restart_reg) st_next = CIMF_ST_WAIT;
					default: if (armed_reg) st_next = CIMF_ST_WAIT;
				endcase
			end
			CIMF_ST_WAIT: begin
				if (qtrig) begin
					st_next = CIMF_ST_OPEN;
					armed_next = 1'b0;
					count_next = 32'h1;
				end
			end
			CIMF_ST_OPEN: begin
				if (qtrig) begin
					count_next = count_reg + 32'h1;
					if (gate_expired) begin
						st_next = CIMF_ST_DONE;
					end
				end
			end
			CIMF_ST_DONE: begin
				if (result_taken) begin
					st_next = CIMF_ST_IDLE;
				end
			end
			default: st_next = CIMF_ST_IDLE;
		endcase
		// Set wins over the start-trigger clear, so a coincident arm edge is kept
		if (ctrl_reg.arm == CIMF_ARM_EXT || ctrl_reg.arm == CIMF_ARM_BURST) begin
			if (ext_arm && !ext_prev_reg) begin
				armed_next = 1'b1;
			end
		end else begin
			armed_next = 1'b0;
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			ctrl_reg <= '0;
			freq_reg <= `CIMF_FREQ_RST;
			mcyc_reg <= `CIMF_MTIME_RST / `CIMF_FREQ_RST * `CIMF_MASK_NUM / `CIMF_MASK_DEN;
			ampl_reg <= 16'h0;
			hyst_reg <= `CIMF_HYST_FIX_MV;
			restart_reg <= 1'b0;
			rdata_reg <= 32'h0;
			st_reg <= CIMF_ST_IDLE;
			armed_reg <= 1'b0;
			ext_prev_reg <= 1'b0;
			count_reg <= 32'h0;
			ta_reg <= 1'b0;
			tb_reg <= 1'b0;
			open_reg <= 1'b0;
			done_reg <= 1'b0;
		end else begin
			ctrl_reg <= ctrl_next;
			freq_reg <= freq_next;
			mcyc_reg <= mcyc_next;
			ampl_reg <= ampl_next;
			hyst_reg <= hyst_next;
			restart_reg <= restart_next;
			rdata_reg <= rdata_next;
			st_reg <= st_next;
			armed_reg <= armed_next;
			ext_prev_reg <= ext_arm;
			count_reg <= count_next;
			ta_reg <= ta_w;
			tb_reg <= tb_w;
			open_reg <= (st_next == CIMF_ST_OPEN);
			done_reg <= (st_reg == CIMF_ST_OPEN) && (st_next == CIMF_ST_DONE);
		end
	end

	assign rdata = rdata_reg;
	assign trig_a = ta_reg;
	assign trig_b = tb_reg;
	assign meas_open = open_reg;
	assign meas_done = done_reg;
	assign hyst_mv = hyst_reg;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	sequence s_open;
		(st_reg == CIMF_ST_WAIT) && qtrig;
	endsequence
	property p_open_on_trig;
		@(posedge ref_clk) disable iff (!arst_n)
		(st_reg == CIMF_ST_WAIT && !qtrig) |=> (st_reg != CIMF_ST_OPEN);
	endproperty
	a_open_on_trig: assert property (p_open_on_trig) else $error("period opened without trigger");
	property p_open_seq;
		@(posedge ref_clk) disable iff (!arst_n)
		s_open |=> (st_reg == CIMF_ST_OPEN) && meas_open;
	endproperty
	a_open_seq: assert property (p_open_seq) else $error("period not opened on trigger");
	property p_close_on_trig;
		@(posedge ref_clk) disable iff (!arst_n)
		(st_reg == CIMF_ST_OPEN && !(qtrig && gate_expired)) |=> (st_reg == CIMF_ST_OPEN);
	endproperty
	a_close_on_trig: assert property (p_close_on_trig) else $error("period closed without trigger");
	property p_one_filter;
		@(posedge ref_clk) disable iff (!arst_n)
		!(fa && fb);
	endproperty
	a_one_filter: assert property (p_one_filter) else $error("filter on both inputs");
	property p_freerun;
		@(posedge ref_clk) disable iff (!arst_n)
		(st_reg == CIMF_ST_IDLE && ctrl_reg.arm == CIMF_ARM_FREE) |=> (st_reg == CIMF_ST_WAIT);
	endproperty
	a_freerun: assert property (p_freerun) else $error("free-run did not rearm");
	property p_hyst;
		@(posedge ref_clk) disable iff (!arst_n)
		(ctrl_reg.auto_trig && func_auto_hyst(ctrl_reg.func))
		|=> (hyst_mv == 16'($past(ampl_reg) / `CIMF_HYST_DIV));
	endproperty
	a_hyst: assert property (p_hyst) else $error("auto hysteresis not a third");
	property p_freq_range;
		@(posedge ref_clk) disable iff (!arst_n)
		(wr && addr == `CIMF_REG_FREQ && (wdata < `CIMF_FILT_HZ_MIN || wdata > `CIMF_FILT_HZ_MAX))
		|=> $stable(freq_reg);
	endproperty
	a_freq_range: assert property (p_freq_range) else $error("out of range frequency taken");
	property p_manual;
		@(posedge ref_clk) disable iff (!arst_n)
		(st_reg == CIMF_ST_IDLE && ctrl_reg.arm == CIMF_ARM_MANUAL && !restart_reg)
		|=> (st_reg == CIMF_ST_IDLE);
	endproperty
	a_manual: assert property (p_manual) else $error("manual mode left idle without restart");
endmodule
`default_nettype wire

//--- rtl/cimf_defs.svh
// Constants for the counter input trigger mask filter
`ifndef CIMF_DEFS_SVH
`define CIMF_DEFS_SVH
`define CIMF_CLK_HZ 32'd125000000
`define CIMF_FILT_HZ_MIN 32'd1
`define CIMF_FILT_HZ_MAX 32'd3000000
`define CIMF_CNT_W 32
`define CIMF_ADDR_W 4
`define CIMF_REG_CTRL 4'h0
`define CIMF_REG_FREQ 4'h1
`define CIMF_REG_CMD 4'h2
`define CIMF_REG_STAT 4'h3
`define CIMF_REG_AMPL 4'h4
`define CIMF_REG_HYST 4'h5
`define CIMF_REG_COUNT 4'h6
`define CIMF_REG_MTIME 4'h7
`define CIMF_FREQ_RST 32'd1000
`define CIMF_HYST_FIX_MV 16'd20
`define CIMF_MTIME_RST 32'd125000000
`define CIMF_MASK_NUM 32'd3
`define CIMF_MASK_DEN 32'd4
`define CIMF_HYST_DIV 16'd3
`endif

//--- rtl/cimf_pkg.sv
// Types for the counter input trigger mask filter
package cimf_pkg;
	typedef enum logic [1:0] {
		CIMF_ARM_FREE = 2'h0,
		CIMF_ARM_MANUAL = 2'h1,
		CIMF_ARM_EXT = 2'h2,
		CIMF_ARM_BURST = 2'h3
	} cimf_arm_t;
	typedef enum logic [1:0] {
		CIMF_FN_FREQ = 2'h0,
		CIMF_FN_PERAVG = 2'h1,
		CIMF_FN_RPM = 2'h2,
		CIMF_FN_TIME = 2'h3
	} cimf_func_t;
	typedef enum logic [1:0] {
		CIMF_ST_IDLE = 2'b00,
		CIMF_ST_WAIT = 2'b01,
		CIMF_ST_OPEN = 2'b11,
		CIMF_ST_DONE = 2'b10
	} cimf_state_t;
	typedef struct packed {
		logic slope_neg_a;
		logic slope_neg_b;
		logic filt_en;
		logic filt_chan_b;
		logic auto_trig;
		cimf_func_t func;
		cimf_arm_t arm;
	} cimf_ctrl_t;
	typedef struct packed {
		logic above_hi;
		logic below_lo;
	} cimf_cmp_t;
endpackage

//--- rtl/cimf_mask.sv
// Mask-time filter for one comparator input
`timescale 1ns/1ps
`default_nettype none
`include "cimf_defs.svh"
module cimf_mask
	import cimf_pkg::*;
(
	input wire logic ref_clk,
	input wire logic arst_n,
	input wire cimf_cmp_t cmp,
	input wire logic slope_neg,
	input wire logic filt_en,
	input wire logic [`CIMF_CNT_W-1:0] mask_cycles,
	output logic trig,
	output logic masking
);
	logic band_hi_reg, band_hi_next;
	logic [`CIMF_CNT_W-1:0] mask_cnt_reg, mask_cnt_next;
	logic cross_up, cross_dn, sel_edge;

	// ----------------------------------------
	// Band crossing and mask counter
	// ----------------------------------------
	always_comb begin
		band_hi_next = band_hi_reg;
		cross_up = 1'b0;
		cross_dn = 1'b0;
		// Only a full traverse of the band flips state
		if (!band_hi_reg && cmp.above_hi) begin
			band_hi_next = 1'b1;
			cross_up = 1'b1;
		end else if (band_hi_reg && cmp.below_lo) begin
			band_hi_next = 1'b0;
			cross_dn = 1'b1;
		end
		sel_edge = slope_neg ? cross_dn : cross_up;
		mask_cnt_next = mask_cnt_reg;
		trig = 1'b0;
		if (filt_en && mask_cnt_reg != '0) begin
			mask_cnt_next = mask_cnt_reg - 1'b1;
		end else if (sel_edge) begin
			// Crossings while counting fall through here unseen
			trig = 1'b1;
			if (filt_en) begin
				mask_cnt_next = mask_cycles;
			end
		end
		if (!filt_en) begin
			// A stale count would swallow the first trigger after re-enable
			mask_cnt_next = '0;
		end
		masking = filt_en && mask_cnt_reg != '0;
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			band_hi_reg <= 1'b0;
			mask_cnt_reg <= '0;
		end else begin
			band_hi_reg <= band_hi_next;
			mask_cnt_reg <= mask_cnt_next;
		end
	end

	property p_mask_blocks;
		@(posedge ref_clk) disable iff (!arst_n)
		(filt_en && mask_cnt_reg != '0) |-> !trig;
	endproperty
	a_mask_blocks: assert property (p_mask_blocks) else $error("trigger passed during mask");
	property p_load;
		@(posedge ref_clk) disable iff (!arst_n)
		(trig && filt_en) |=> (mask_cnt_reg == $past(mask_cycles));
	endproperty
	a_load: assert property (p_load) else $error("mask not loaded on trigger");
	property p_mask_count;
		@(posedge ref_clk) disable iff (!arst_n)
		(filt_en && mask_cnt_reg != '0) |=> (mask_cnt_reg == $past(mask_cnt_reg) - 1'b1);
	endproperty
	a_mask_count: assert property (p_mask_count) else $error("mask counter did not step down");
endmodule
`default_nettype wire

//--- testbench/cimf_front_model.sv
// Comparator front end model producing noisy band flags
`timescale 1ns/1ps
`default_nettype none
module cimf_front_model
	import cimf_pkg::*;
(
	input wire logic ref_clk,
	output cimf_cmp_t cmp_a,
	output cimf_cmp_t cmp_b
);
	localparam cimf_cmp_t HI = 2'h2;
	localparam cimf_cmp_t MID = 2'h0;
	localparam cimf_cmp_t LO = 2'h1;
	initial begin
		cmp_a = LO;
		cmp_b = LO;
	end
	task automatic put(input cimf_cmp_t v, input int k);
		cmp_a <= v;
		cmp_b <= v;
		repeat (k) @(posedge ref_clk);
	endtask
	// ----------------------------------------
	// Signal cycles, both inputs alike
	// ----------------------------------------
	// Mid dips stay inside the band, spikes cross it fully
	task automatic run(input int n, input int period);
		for (int i = 0; i < n; i++) begin
			put(HI, 1);
			put(MID, 1);
			put(HI, 1);
			put(LO, 1);
			put(HI, period / 2 - 4);
			put(LO, 1);
			put(MID, 1);
			put(LO, 1);
			put(HI, 1);
			put(LO, period - period / 2 - 4);
		end
	endtask
endmodule
`default_nettype wire

//--- testbench/tb.sv
// Self-checking bench for the trigger mask filter top
`timescale 1ns/1ps
`default_nettype none
`include "cimf_defs.svh"
module tb
	import cimf_pkg::*;
;
	// ----------------------------------------
	// Signals
	// ----------------------------------------
	logic ref_clk = 1'b0;
	logic arst_n = 1'b0;
	logic [`CIMF_ADDR_W-1:0] addr = '0;
	logic [31:0] wdata = '0;
	logic wr = 1'b0, rd = 1'b0, ext_arm = 1'b0, gate_expired = 1'b0, result_taken = 1'b1;
	logic [31:0] rdata;
	cimf_cmp_t cmp_a, cmp_b;
	logic trig_a, trig_b, meas_open, meas_done, open_q;
	logic [15:0] hyst_mv;
	int n_mismatch = 0, check_count = 0, na = 0, nb = 0, nd = 0, cyc = 0, last_trig = -100, snd;
	logic [31:0] fexp;
	logic [31:0] fl [5] = '{32'hF4240, 32'h1, 32'h0, 32'h2DC6C1, 32'h2DC6C0};
	always #4 ref_clk = ~ref_clk;
	cimf_front_model u_cimf_front_model (.ref_clk(ref_clk), .cmp_a(cmp_a), .cmp_b(cmp_b));
	cimf_top u_cimf_top (.ref_clk(ref_clk), .arst_n(arst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata(rdata), .cmp_a(cmp_a), .cmp_b(cmp_b), .ext_arm(ext_arm), .gate_expired(gate_expired),
		.result_taken(result_taken), .trig_a(trig_a), .trig_b(trig_b), .meas_open(meas_open),
		.meas_done(meas_done), .hyst_mv(hyst_mv));
	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD %s exp %0h got %0h", nm, exp, got);
		end
	endtask
	task automatic wr_reg(input logic [`CIMF_ADDR_W-1:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge ref_clk);
		wr <= 1'b0;
	endtask
	task automatic rd_chk(input string nm, input logic [`CIMF_ADDR_W-1:0] a, input logic [31:0] exp);
		@(posedge ref_clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge ref_clk);
		rd <= 1'b0;
		#1;
		chk(nm, rdata, exp);
	endtask
	function automatic logic [31:0] ctrl(logic sa, logic fe, logic fb, logic au, cimf_func_t fn, cimf_arm_t am);
		cimf_ctrl_t c;
		c = '{sa, sa, fe, fb, au, fn, am};
		return {23'h0, c};
	endfunction
	task automatic do_reset;
		@(posedge ref_clk);
		arst_n <= 1'b0;
		repeat (10) @(posedge ref_clk);
		arst_n <= 1'b1;
	endtask
	// Filter at 3 MHz, signal at 42 cycles per period keeps within range
	task automatic filt_case(input logic sa, fe, fb, input cimf_func_t fn, input int ea, eb);
		int sna, snb;
		wr_reg(`CIMF_REG_CTRL, ctrl(sa, fe, fb, 1'b0, fn, CIMF_ARM_FREE));
		sna = na;
		snb = nb;
		u_cimf_front_model.run(4, 42);
		repeat (4) @(posedge ref_clk);
		chk("trig_a count", na - sna, 4 * ea);
		chk("trig_b count", nb - snb, 4 * eb);
	endtask
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// ----------------------------------------
	// Monitors
	// ----------------------------------------
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		open_q <= meas_open;
		if (trig_a === 1'b1) na <= na + 1;
		if (trig_a === 1'b1) last_trig <= cyc;
		if (trig_b === 1'b1) nb <= nb + 1;
		if (meas_done === 1'b1) nd <= nd + 1;
		if (meas_done === 1'b1 || (meas_open === 1'b1 && open_q !== 1'b1))
			chk("meas align", {31'h0, trig_a === 1'b1 || cyc - last_trig <= 2}, 32'h1);
	end
	initial begin
		repeat (100000) @(posedge ref_clk);
		n_mismatch++;
		$display("BAD watchdog exp done got hang");
		wrap_up;
	end
	// ----------------------------------------
	// Sequence
	// ----------------------------------------
	initial begin
		do_reset;
		#1;
		chk("hyst_mv", {16'h0, hyst_mv}, 32'h14);
		rd_chk("ctrl", `CIMF_REG_CTRL, 32'h0);
		rd_chk("freq", `CIMF_REG_FREQ, 32'h3E8);
		rd_chk("stat", `CIMF_REG_STAT, 32'h2);
		wr_reg(4'hA, 32'hFFFFFFFF);
		rd_chk("unmapped", 4'hA, 32'h0);
		$display("test reset done");
		fexp = 32'h3E8;
		for (int i = 0; i < 5; i++) begin
			wr_reg(`CIMF_REG_FREQ, fl[i]);
			if (fl[i] >= `CIMF_FILT_HZ_MIN && fl[i] <= `CIMF_FILT_HZ_MAX) fexp = fl[i];
			rd_chk("freq", `CIMF_REG_FREQ, fexp);
			rd_chk("mtime", `CIMF_REG_MTIME, (`CIMF_CLK_HZ * 3) / (4 * fexp));
		end
		$display("test filter frequency done");
		wr_reg(`CIMF_REG_AMPL, 32'h12C);
		for (int i = 0; i < 5; i++) begin
			wr_reg(`CIMF_REG_CTRL, ctrl(1'b0, 1'b0, 1'b0, i < 4, cimf_func_t'(i[1:0]), CIMF_ARM_FREE));
			rd_chk("hyst", `CIMF_REG_HYST, (i < 3) ? 32'h64 : 32'h14);
			chk("hyst_mv", {16'h0, hyst_mv}, (i < 3) ? 32'h64 : 32'h14);
		end
		$display("test hysteresis done");
		filt_case(1'b0, 1'b0, 1'b0, CIMF_FN_FREQ, 3, 3);
		filt_case(1'b1, 1'b0, 1'b0, CIMF_FN_FREQ, 3, 3);
		filt_case(1'b0, 1'b1, 1'b0, CIMF_FN_FREQ, 1, 3);
		filt_case(1'b1, 1'b1, 1'b0, CIMF_FN_PERAVG, 1, 3);
		filt_case(1'b0, 1'b1, 1'b1, CIMF_FN_RPM, 3, 1);
		filt_case(1'b0, 1'b1, 1'b0, CIMF_FN_TIME, 3, 3);
		$display("test mask filter done");
		for (int m = 0; m < 4; m++) begin
			do_reset;
			wr_reg(`CIMF_REG_CTRL, ctrl(1'b0, 1'b0, 1'b0, 1'b0, CIMF_FN_FREQ, cimf_arm_t'(m)));
			// Reset default is free-run, already waiting: close that period first
			gate_expired <= 1'b1;
			u_cimf_front_model.run(1, 42);
			gate_expired <= 1'b0;
			u_cimf_front_model.run(3, 42);
			chk("open before arm", {31'h0, meas_open}, {31'h0, m == 0});
			if (m == 1) wr_reg(`CIMF_REG_CMD, 32'h1);
			if (m >= 2) begin
				@(posedge ref_clk);
				ext_arm <= 1'b1;
				@(posedge ref_clk);
				ext_arm <= 1'b0;
			end
			u_cimf_front_model.run(2, 42);
			chk("open after arm", {31'h0, meas_open}, 32'h1);
			snd = nd;
			gate_expired <= 1'b1;
			u_cimf_front_model.run(2, 42);
			gate_expired <= 1'b0;
			chk("done seen", {31'h0, nd > snd}, 32'h1);
		end
		$display("test arming done");
		wrap_up;
	end
endmodule
`default_nettype wire
